// >>> reset_watchdog_defines.vh
// constants for the reset, power-on timer and watchdog block
`ifndef RESET_WATCHDOG_DEFINES_VH
`define RESET_WATCHDOG_DEFINES_VH
`define ADDR_WATCHDOG_MODE      2'h0
`define ADDR_STOP_RECOVERY      2'h1
`define ADDR_CONTROL            2'h2
`define ADDR_STATUS             2'h3
`define WDM_RESET               8'h0d
`define SRC_RESET               8'h00
`define WDM_TAP_LO              0
`define WDM_HALT_RUN            2
`define WDM_STOP_RUN            3
`define WDM_XTAL_SRC            4
`define SRC_DIV16               0
`define SRC_NO_DIV2             1
`define SRC_WAKE_LO             2
`define SRC_POR_BYPASS          5
`define SRC_STOP_FLAG           7
`define CTL_REFRESH             0
`define CTL_HALT                1
`define CTL_STOP                2
`define CTL_PERMANENT           3
`define FILTER_CLOCKS           3'h4
`define HOLD_CLOCKS             5'h12
`define POR_TIME_US             5000
`define RC_PERIOD_NS            1000
`define WD_MS_UNIT              5
`define SCLK_BASE               128
`define VECTOR_ADDR             16'h000c
`define FETCH_DELAY_MIN         5
`define CORE_CLK_NS             50
`endif

// >>> reset_filter.v
// external reset synchroniser, four-clock filter and stretch
`timescale 1ns/1ns
`default_nettype none
`include "reset_watchdog_defines.vh"
module reset_filter
(
    input  wire       core_clk,
    input  wire       reset,
    input  wire       ext_reset_n,
    output reg        ext_rst_active
);
    reg        sync1_reg;
    reg        sync2_reg;
    reg  [2:0] low_cnt_reg;
    reg  [4:0] hold_cnt_reg;
    always @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            sync1_reg      <= 1'b1;
            sync2_reg      <= 1'b1;
            low_cnt_reg    <= 3'h0;
            hold_cnt_reg   <= 5'h00;
            ext_rst_active <= 1'b0;
        end
        else
        begin
            sync1_reg <= ext_reset_n;
            sync2_reg <= sync1_reg;
            if (sync2_reg)
                low_cnt_reg <= 3'h0;
            else if (low_cnt_reg != `FILTER_CLOCKS)
                low_cnt_reg <= low_cnt_reg + 3'h1;
            // short pulses never reach the count and are dropped
            if (!sync2_reg && low_cnt_reg == `FILTER_CLOCKS)
            begin
                ext_rst_active <= 1'b1;
                if (!ext_rst_active)
                    hold_cnt_reg <= `HOLD_CLOCKS;
            end
            if (ext_rst_active)
            begin
                if (hold_cnt_reg != 5'h00)
                    hold_cnt_reg <= hold_cnt_reg - 5'h01;
                // longer of 18 clocks or the pin low time
                if (hold_cnt_reg <= 5'h01 && sync2_reg)
                    ext_rst_active <= 1'b0;
            end
        end
    end
endmodule // reset_filter
`default_nettype wire

// >>> watchdog_counter.v
// watchdog and power-on one-shot counter, one instance per timer
`timescale 1ns/1ns
`default_nettype none
`include "reset_watchdog_defines.vh"
module watchdog_counter
#(
    parameter CNT_W = 24
)
(
    input  wire             core_clk,
    input  wire             reset,
    input  wire             tick,
    input  wire             restart,
    input  wire             run,
    input  wire [CNT_W-1:0] limit,
    output reg              expired
);
    reg [CNT_W-1:0] count_reg;
    always @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            count_reg <= {CNT_W{1'b0}};
            expired   <= 1'b0;
        end
        else if (restart)
        begin
            count_reg <= {CNT_W{1'b0}};
            expired   <= 1'b0;
        end
        else if (run && tick && !expired)
        begin
            if (count_reg + 1'b1 >= limit)
                expired <= 1'b1;
            count_reg <= count_reg + 1'b1;
        end
    end
endmodule // watchdog_counter
`default_nettype wire

// >>> reset_clock_control.v
// reset, power-on timer, watchdog and clock control of the core
//
// Contract
// - low pulses shorter than four input clocks cause no reset
// - fifth clock latches reset, held 18 clocks or pin time if longer
// - during reset data strobe held low, address strobe toggles
// - fetch from 000c starts five to ten clocks after release
// - power-on and watchdog reset drive the open-drain pin low
// - power-on timer fires on power good, timeout, stop recovery
// - power-on timer from the rc oscillator delays execution 5 ms; counts the pin clock instead when mode bit 4 is set
// - halt stops cpu clock, interrupt exits, resumes after halt
// - stop recovery bit 0 enables divide-by-16 clock prescaler
// - stop recovery bit 1 zero divides clocks by two, one bypasses
// - stop recovery bits 2 to 4 pick the stop wake source
// - stop recovery write-only except bit 7 which is read-only
// - refresh instruction enables and restarts the watchdog
// - refresh instruction updates zero, sign and overflow flags
// - mode bits 1:0 select timeout; rc or system clock taps
// - mode bit 2 keeps watchdog running in halt, default one
// - mode bit 3 keeps watchdog in stop, rc clock only
// - mode bit 4 selects oscillator pin clock, stops it in stop
// - permanent option runs watchdog from reset regardless of bits; here set by a control bit 3 write, mode bit 4 still stops it in stop
// - four reset sources: power-on, timeout, stop recovery, pin
//
// Added by the designer: the Avalon-MM slave port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
`include "reset_watchdog_defines.vh"
module reset_clock_control
#(
    parameter POR_CYCLES = (`POR_TIME_US * 1000) / `CORE_CLK_NS,
    parameter RC_DIV     = `RC_PERIOD_NS / `CORE_CLK_NS,
    parameter MS_RC_TICKS = 1000000 / `RC_PERIOD_NS
)
(
    input  wire        core_clk,
    input  wire        reset,
    input  wire [1:0]  avs_address,
    input  wire        avs_read,
    input  wire        avs_write,
    input  wire [31:0] avs_writedata,
    output reg  [31:0] avs_readdata,
    output reg         avs_waitrequest,
    input  wire        ext_reset_n_in,
    output reg         reset_pin_out,
    output reg         reset_pin_oe,
    input  wire        power_good,
    input  wire        oscillator_input_pin,
    input  wire        interrupt_request,
    input  wire [2:0]  wake_sources,
    output reg         core_reset,
    output reg         data_strobe_out_n,
    output reg         address_strobe_out,
    output reg         fetch_start,
    output reg  [15:0] fetch_address,
    output reg         cpu_clk_en,
    output reg         timer_clock_en,
    output reg         halted,
    output reg         stopped,
    output reg         flags_update,
    output reg  [2:0]  wake_select,
    output reg  [3:0]  reset_cause
);
    localparam ST_RESET = 2'd0;
    localparam ST_WAIT  = 2'd1;
    localparam ST_RUN   = 2'd2;
    reg  [7:0]  watchdog_mode_control;
    reg  [7:0]  stop_recovery_clock_control;
    reg         permanent_reg;
    reg         wd_enabled_reg;
    reg         stop_flag_reg;
    reg         pg_reg;
    reg  [1:0]  state_reg;
    reg  [3:0]  fetch_cnt_reg;
    reg  [15:0] rc_cnt_reg;
    reg         rc_tick_reg;
    reg         xtal_q_reg;
    reg         xtal_tick_reg;
    reg         div2_reg;
    reg  [3:0]  div16_reg;
    reg         por_start_reg;
    reg         wd_restart_reg;
    wire        ext_rst;
    wire        por_done;
    wire        wd_timeout;
    wire        wd_tick;
    wire        wd_run;
    wire [23:0] wd_limit;
    wire        por_tick;
    wire        sel;
    wire        write_mode;
    wire        write_src;
    wire        write_ctl;
    wire        wake_hit;
    wire        div_base;

    // timeout taps: 5,10,20,80 ms or 128,256,512,2048 clocks
    function [23:0] wd_taps;
        input [1:0]  tap;
        input        xtal;
        reg   [4:0]  mult;
        reg   [31:0] span;
        begin
            mult = (tap == 2'h3) ? 5'd16 : (5'd1 << tap);
            if (xtal)
                span = `SCLK_BASE * mult;
            else
                span = `WD_MS_UNIT * MS_RC_TICKS * mult;
            wd_taps = span[23:0];
        end
    endfunction

    assign sel        = !avs_waitrequest;
    assign write_mode = avs_write && sel && avs_address == `ADDR_WATCHDOG_MODE;
    assign write_src  = avs_write && sel && avs_address == `ADDR_STOP_RECOVERY;
    assign write_ctl  = avs_write && sel && avs_address == `ADDR_CONTROL;
    assign wake_hit   = stopped && |(wake_sources & wake_select);
    // rc source unless the pin clock is picked
    assign wd_tick    = watchdog_mode_control[`WDM_XTAL_SRC] ?
                        xtal_tick_reg : rc_tick_reg;
    assign por_tick   = wd_tick;
    assign wd_limit   = wd_taps(watchdog_mode_control[1:0],
                                watchdog_mode_control[`WDM_XTAL_SRC]);
    assign wd_run = (wd_enabled_reg || permanent_reg) && state_reg == ST_RUN &&
                    (stopped ? !watchdog_mode_control[`WDM_XTAL_SRC] &&
                               (permanent_reg ||
                                watchdog_mode_control[`WDM_STOP_RUN]) :
                     halted  ? (permanent_reg ||
                                watchdog_mode_control[`WDM_HALT_RUN]) :
                     1'b1);
    assign div_base = stop_recovery_clock_control[`SRC_NO_DIV2] | div2_reg;

    reset_filter u_filter
    (
        .core_clk       (core_clk),
        .reset          (reset),
        // our own drive of the pin is no external reset
        .ext_reset_n    (ext_reset_n_in | reset_pin_oe),
        .ext_rst_active (ext_rst)
    );

    watchdog_counter #(.CNT_W(24)) u_por
    (
        .core_clk (core_clk),
        .reset    (reset),
        .tick     (por_tick),
        .restart  (por_start_reg),
        .run      (1'b1),
        .limit    (POR_CYCLES[23:0] / RC_DIV[23:0]),
        .expired  (por_done)
    );

    watchdog_counter #(.CNT_W(24)) u_wd
    (
        .core_clk (core_clk),
        .reset    (reset),
        .tick     (wd_tick),
        .restart  (wd_restart_reg),
        .run      (wd_run),
        .limit    (wd_limit),
        .expired  (wd_timeout)
    );

    always @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            watchdog_mode_control       <= `WDM_RESET;
            stop_recovery_clock_control <= `SRC_RESET;
            permanent_reg      <= 1'b0;
            wd_enabled_reg     <= 1'b0;
            stop_flag_reg      <= 1'b0;
            pg_reg             <= 1'b0;
            state_reg          <= ST_RESET;
            fetch_cnt_reg      <= 4'h0;
            rc_cnt_reg         <= 16'h0000;
            rc_tick_reg        <= 1'b0;
            xtal_q_reg         <= 1'b0;
            xtal_tick_reg      <= 1'b0;
            div2_reg           <= 1'b0;
            div16_reg          <= 4'h0;
            por_start_reg      <= 1'b1;
            wd_restart_reg     <= 1'b1;
            avs_readdata       <= 32'h00000000;
            avs_waitrequest    <= 1'b1;
            reset_pin_out      <= 1'b0;
            reset_pin_oe       <= 1'b0;
            core_reset         <= 1'b1;
            data_strobe_out_n  <= 1'b0;
            address_strobe_out <= 1'b0;
            fetch_start        <= 1'b0;
            fetch_address      <= 16'h0000;
            cpu_clk_en         <= 1'b0;
            timer_clock_en     <= 1'b0;
            halted             <= 1'b0;
            stopped            <= 1'b0;
            flags_update       <= 1'b0;
            wake_select        <= 3'h0;
            reset_cause        <= 4'h0;
        end
        else
        begin
            por_start_reg  <= 1'b0;
            wd_restart_reg <= 1'b0;
            flags_update   <= 1'b0;
            fetch_start    <= 1'b0;
            // dedicated rc oscillator modelled as a divided tick
            rc_tick_reg <= (rc_cnt_reg == RC_DIV[15:0] - 16'h0001);
            rc_cnt_reg  <= (rc_cnt_reg == RC_DIV[15:0] - 16'h0001) ?
                           16'h0000 : rc_cnt_reg + 16'h0001;
            xtal_q_reg    <= oscillator_input_pin;
            xtal_tick_reg <= oscillator_input_pin & ~xtal_q_reg;
            div2_reg  <= ~div2_reg;
            // bit 1 high bypasses the halving
            if (div_base)
                div16_reg <= div16_reg + 4'h1;
            cpu_clk_en <= div_base && state_reg == ST_RUN && !halted &&
                          !stopped &&
                          (!stop_recovery_clock_control[`SRC_DIV16] ||
                           div16_reg == 4'hf);
            timer_clock_en <= div_base && !stopped &&
                              (!stop_recovery_clock_control[`SRC_DIV16] ||
                               div16_reg == 4'hf);
            // bus slave, one wait state per access
            avs_waitrequest <= !(avs_read || avs_write) || !avs_waitrequest;
            if (avs_read && avs_waitrequest)
                case (avs_address)
                    `ADDR_WATCHDOG_MODE: avs_readdata <=
                        {27'h0, watchdog_mode_control[4:0]};
                    // only the stop flag is readable
                    `ADDR_STOP_RECOVERY: avs_readdata <=
                        {24'h0, stop_flag_reg, 7'h00};
                    `ADDR_STATUS: avs_readdata <=
                        {24'h0, reset_cause, wd_enabled_reg | permanent_reg,
                         stopped, halted, core_reset};
                    default: avs_readdata <= 32'h00000000;
                endcase
            if (write_mode)
                watchdog_mode_control <= {3'h0, avs_writedata[4:0]};
            if (write_src)
                stop_recovery_clock_control <= {1'b0, avs_writedata[6:0]};
            wake_select <= stop_recovery_clock_control[4:2];
            if (write_ctl && avs_writedata[`CTL_PERMANENT])
                permanent_reg <= 1'b1;
            if (write_ctl && avs_writedata[`CTL_REFRESH] &&
                state_reg == ST_RUN)
            begin
                wd_enabled_reg <= 1'b1;
                wd_restart_reg <= 1'b1;
                flags_update   <= 1'b1;
            end
            if (write_ctl && avs_writedata[`CTL_HALT] && state_reg == ST_RUN)
                halted <= 1'b1;
            if (write_ctl && avs_writedata[`CTL_STOP] && state_reg == ST_RUN)
                stopped <= 1'b1;
            // interrupt exits halt; cpu resumes after the halt
            if (halted && interrupt_request)
                halted <= 1'b0;
            pg_reg <= power_good;
            // reset sources and power-on trigger
            if (power_good && !pg_reg)
            begin
                por_start_reg <= 1'b1;
                state_reg     <= ST_RESET;
                reset_cause   <= 4'h1;
            end
            else if (wd_timeout && wd_run)
            begin
                por_start_reg  <= 1'b1;
                wd_restart_reg <= 1'b1;
                state_reg      <= ST_RESET;
                reset_cause    <= 4'h2;
            end
            else if (wake_hit)
            begin
                stopped       <= 1'b0;
                stop_flag_reg <= 1'b1;
                reset_cause   <= 4'h4;
                state_reg     <= ST_RESET;
                por_start_reg <= !stop_recovery_clock_control[`SRC_POR_BYPASS];
            end
            else if (ext_rst)
            begin
                state_reg   <= ST_RESET;
                reset_cause <= 4'h8;
            end
            case (state_reg)
                ST_RESET:
                begin
                    core_reset <= 1'b1;
                    halted     <= 1'b0;
                    // por_done is stale on the trigger edge
                    if (!ext_rst && !por_start_reg && (por_done ||
                        reset_cause == 4'h8 || reset_cause == 4'h4 &&
                        stop_recovery_clock_control[`SRC_POR_BYPASS]))
                    begin
                        state_reg     <= ST_WAIT;
                        fetch_cnt_reg <= 4'h0;
                    end
                end
                ST_WAIT:
                begin
                    fetch_cnt_reg <= fetch_cnt_reg + 4'h1;
                    if (fetch_cnt_reg == `FETCH_DELAY_MIN - 1)
                    begin
                        state_reg     <= ST_RUN;
                        core_reset    <= 1'b0;
                        fetch_start   <= 1'b1;
                        fetch_address <= `VECTOR_ADDR;
                    end
                end
                ST_RUN:
                    core_reset <= 1'b0;
                default:
                    state_reg <= ST_RESET;
            endcase
            // strobes during reset
            data_strobe_out_n  <= !(state_reg != ST_RUN);
            address_strobe_out <= (state_reg != ST_RUN) ?
                                  ~address_strobe_out : 1'b1;
            // open-drain drive for internal power-on and timeout
            reset_pin_out <= 1'b0;
            reset_pin_oe  <= state_reg == ST_RESET && !por_done &&
                             (reset_cause == 4'h1 || reset_cause == 4'h2);
        end
    end
endmodule // reset_clock_control
`default_nettype wire

// >>> rcc_props.sv
// port-level checks on the reset, watchdog and clock control block
`timescale 1ns/1ns
`default_nettype none
module rcc_props
(
    input wire logic        core_clk,
    input wire logic        reset,
    input wire logic [1:0]  avs_address,
    input wire logic        avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic        avs_waitrequest,
    input wire logic        ext_reset_n_in,
    input wire logic        reset_pin_out,
    input wire logic        reset_pin_oe,
    input wire logic        interrupt_request,
    input wire logic        core_reset,
    input wire logic        data_strobe_out_n,
    input wire logic        address_strobe_out,
    input wire logic        fetch_start,
    input wire logic [15:0] fetch_address,
    input wire logic        cpu_clk_en,
    input wire logic        halted,
    input wire logic        flags_update,
    input wire logic [3:0]  reset_cause
);
    logic [4:0] hi_cnt;
    logic [1:0] up_cnt;
    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);
    // saturating, so long power-on holds never wrap the count
    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            hi_cnt <= 5'h0;
            up_cnt <= 2'h0;
        end
        else
        begin
            hi_cnt <= !core_reset ? 5'h0 : (&hi_cnt) ? hi_cnt : hi_cnt + 5'h1;
            up_cnt <= (&up_cnt) ? up_cnt : up_cnt + 2'h1;
        end
    end
    ds_low_a:
        assert property (core_reset |-> !data_strobe_out_n)
        else $error("data strobe not low in reset");
    as_toggle_a:
        assert property ((&up_cnt) && core_reset && $past(core_reset)
            |-> address_strobe_out != $past(address_strobe_out))
        else $error("address strobe not toggling in reset");
    fetch_addr_a:
        assert property (fetch_start |-> fetch_address == 16'h000c
            && !core_reset)
        else $error("fetch from wrong address");
    fetch_window_a:
        // long resets only, so the hold count is no longer in play
        assert property ($rose(ext_reset_n_in) && (&hi_cnt)
            |-> ##[5:10] fetch_start)
        else $error("fetch not started in time");
    pin_drive_a:
        assert property (reset_pin_oe |-> !reset_pin_out && core_reset)
        else $error("reset pin driven wrongly");
    short_pulse_a:
        assert property ((!core_reset && ext_reset_n_in)
            ##1 (!ext_reset_n_in) [*3] ##1 ext_reset_n_in
            |-> !core_reset [*6])
        else $error("short pulse caused reset");
    long_pulse_a:
        assert property ((!ext_reset_n_in && !reset_pin_oe) [*8]
            |-> ##2 core_reset)
        else $error("long pulse gave no reset");
    hold_min_a:
        // bypassed stop wake is short on purpose
        assert property ($fell(core_reset) && reset_cause != 4'h4
            |-> hi_cnt >= 5'h12)
        else $error("reset held under 18 clocks");
    refresh_flags_a:
        assert property (avs_write && avs_waitrequest && avs_address == 2'h2
            && avs_writedata[0] |-> ##[1:3] flags_update)
        else $error("refresh gave no flag update");
    halt_clock_a:
        assert property (halted && $past(halted) |-> !cpu_clk_en)
        else $error("cpu clock runs in halt");
    halt_exit_a:
        assert property (halted && interrupt_request |-> ##[1:4] !halted)
        else $error("interrupt did not end halt");
endmodule // rcc_props
bind reset_clock_control rcc_props chk_u
(
    .core_clk(core_clk), .reset(reset), .avs_address(avs_address),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_waitrequest(avs_waitrequest), .ext_reset_n_in(ext_reset_n_in),
    .reset_pin_out(reset_pin_out), .reset_pin_oe(reset_pin_oe),
    .interrupt_request(interrupt_request), .core_reset(core_reset),
    .data_strobe_out_n(data_strobe_out_n),
    .address_strobe_out(address_strobe_out), .fetch_start(fetch_start),
    .fetch_address(fetch_address), .cpu_clk_en(cpu_clk_en),
    .halted(halted), .flags_update(flags_update),
    .reset_cause(reset_cause)
);
`default_nettype wire

// >>> reset_pin_partner.sv
// open-drain external reset source sharing the pulled-up reset line
`timescale 1ns/1ns
`default_nettype none
module reset_pin_partner
(
    input  wire logic core_clk,
    input  wire logic dut_oe,
    input  wire logic dut_out,
    output wire logic pin_level
);
    logic pull_low;
    initial pull_low = 1'b0;
    // wired-and with pull-up: nobody ever drives the line high
    assign pin_level = ~(pull_low | (dut_oe & ~dut_out));
    task automatic pulse(input int n);
        begin
            @(posedge core_clk);
            pull_low <= 1'b1;
            repeat (n) @(posedge core_clk);
            pull_low <= 1'b0;
        end
    endtask
endmodule // reset_pin_partner
`default_nettype wire

// >>> reset_clock_control_test.sv
// self-checking bench for the reset, watchdog and clock control
`timescale 1ns/1ns
`default_nettype none
module reset_clock_control_test;
    logic        core_clk, reset, avs_read, avs_write, power_good;
    logic        osc_pin, irq;
    logic [1:0]  avs_address;
    logic [31:0] avs_writedata, q;
    logic [2:0]  wake;
    wire  [31:0] rdata;
    wire  [15:0] faddr;
    wire  [3:0]  cause;
    wire  [2:0]  wsel;
    wire         wreq, pin_out, pin_oe, pin_level, core_reset, ds_n, as_o;
    wire         fstart, cpu_en, tmr_en, halted, stopped, flags_up;
    int          n_fail, compares, ce, te, k;

    reset_clock_control #(.POR_CYCLES(200), .RC_DIV(2), .MS_RC_TICKS(2))
    dut_u
    (
        .core_clk(core_clk), .reset(reset), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(rdata),
        .avs_waitrequest(wreq), .ext_reset_n_in(pin_level),
        .reset_pin_out(pin_out), .reset_pin_oe(pin_oe),
        .power_good(power_good), .oscillator_input_pin(osc_pin),
        .interrupt_request(irq), .wake_sources(wake),
        .core_reset(core_reset), .data_strobe_out_n(ds_n),
        .address_strobe_out(as_o), .fetch_start(fstart),
        .fetch_address(faddr), .cpu_clk_en(cpu_en),
        .timer_clock_en(tmr_en), .halted(halted), .stopped(stopped),
        .flags_update(flags_up), .wake_select(wsel), .reset_cause(cause)
    );
    reset_pin_partner pin_u
    (
        .core_clk(core_clk), .dut_oe(pin_oe), .dut_out(pin_out),
        .pin_level(pin_level)
    );

    always #25 core_clk = ~core_clk;
    always @(posedge core_clk) osc_pin <= ~osc_pin;

    task automatic chk(input logic c, input string m);
        begin
            compares++;
            if (c !== 1'b1)
            begin
                n_fail++;
                $display("BAD %0t %s", $time, m);
            end
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    task automatic acc(input logic we, input logic [1:0] a,
                       input logic [7:0] d);
        begin
            @(posedge core_clk);
            avs_address   <= a;
            avs_writedata <= {24'h0, d};
            avs_write     <= we;
            avs_read      <= !we;
            do
                @(posedge core_clk);
            while (wreq !== 1'b0);
            q = rdata;
            avs_write <= 1'b0;
            avs_read  <= 1'b0;
        end
    endtask
    task automatic count_en;
        begin
            ce = 0;
            te = 0;
            step(4);
            repeat (32)
            begin
                @(posedge core_clk);
                ce += cpu_en;
                te += tmr_en;
            end
        end
    endtask
    task automatic wait_run;
        begin
            k = 0;
            while (core_reset !== 1'b0 && k < 2000)
            begin
                @(posedge core_clk);
                k++;
            end
            chk(core_reset === 1'b0, "core never left reset");
            step(12);
        end
    endtask
    task automatic t_regs;
        begin
            acc(0, 2'h0, 8'h0); chk(q[7:0] === 8'h0d, "mode reset");
            acc(0, 2'h1, 8'h0); chk(q[6:0] === 7'h0, "stop rec read");
            count_en; chk(ce == 16 && te == 16, "default div2");
            acc(1, 2'h1, 8'h02); count_en; chk(ce == 32 && te == 32, "div1");
            acc(1, 2'h1, 8'h03); count_en; chk(ce == 2 && te == 2, "div16");
            acc(1, 2'h1, 8'h14); step(2);
            chk(wsel === 3'h5, "wake select");
            acc(0, 2'h1, 8'h0); chk(q[6:0] === 7'h0, "write only");
        end
    endtask
    task automatic t_pin(input int n);
        int   hi;
        logic f;
        begin
            hi = 0;
            f = 1'b0;
            fork
                pin_u.pulse(n);
            join_none
            repeat (n + 40)
            begin
                @(posedge core_clk);
                hi += core_reset;
                if (fstart === 1'b1)
                    f = (faddr === 16'h000c);
            end
            if (n < 4)
                chk(hi == 0, "short pulse reset");
            else
            begin
                chk(hi >= 18 && hi >= n - 8, "reset hold");
                chk(f && cause === 4'h8, "pin reset");
            end
        end
    endtask
    task automatic t_halt;
        begin
            acc(1, 2'h2, 8'h02);
            count_en; chk(halted === 1'b1 && ce == 0, "halt");
            irq <= 1'b1;
            step(6);
            irq <= 1'b0;
            chk(halted === 1'b0, "halt exit");
        end
    endtask
    task automatic t_watchdog;
        begin
            // oscillator pin ticks every second clock: 128 ticks = 256
            acc(1, 2'h0, 8'h10);
            repeat (3)
            begin
                acc(1, 2'h2, 8'h01);
                step(180);
            end
            chk(core_reset === 1'b0, "refresh restart");
            acc(1, 2'h2, 8'h01);
            k = 0;
            while (core_reset !== 1'b1 && k < 400)
            begin
                @(posedge core_clk);
                k++;
            end
            chk(k >= 240 && k <= 300, "timeout span");
            step(2);
            chk(pin_oe === 1'b1 && cause === 4'h2, "wd reset");
            wait_run;
        end
    endtask
    task automatic t_stop;
        begin
            acc(1, 2'h1, 8'h24);
            acc(1, 2'h2, 8'h04);
            step(2);
            chk(stopped === 1'b1, "stop");
            wake <= 3'h1;
            step(10);
            wake <= 3'h0;
            chk(cause === 4'h4 && pin_oe === 1'b0, "stop wake");
            wait_run;
        end
    endtask
    task automatic t_power;
        begin
            power_good <= 1'b0;
            step(4);
            power_good <= 1'b1;
            step(4);
            chk(core_reset === 1'b1 && cause === 4'h1, "power");
            chk(pin_oe === 1'b1, "power pin");
            wait_run;
        end
    endtask
    task automatic tally_and_finish;
        begin
            $display("compares %0d n_fail %0d", compares, n_fail);
            if (n_fail == 0 && compares > 0)
                $display("ALL TESTS PASSED");
            else
                $display("TESTS FAILED");
            $finish;
        end
    endtask

    initial
    begin
        {core_clk, avs_read, avs_write, osc_pin, irq} = 5'h0;
        {n_fail, compares} = 0;
        avs_address = 2'h0;
        avs_writedata = 32'h0;
        wake = 3'h0;
        power_good = 1'b1;
        reset = 1'b1;
        step(4);
        reset <= 1'b0;
        wait_run;
        t_regs;
        t_pin(3);
        t_pin(8);
        t_pin(30);
        t_halt;
        t_watchdog;
        t_stop;
        t_power;
        tally_and_finish;
    end
    initial
    begin
        #1000000;
        n_fail++;
        $display("BAD %0t run hung", $time);
        tally_and_finish;
    end
endmodule // reset_clock_control_test
`default_nettype wire
